// ### rtl/sre_cfg.svh
// Offsets, field positions, reset values for the soft reset exception unit
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH

// ============================================================
// Register byte offsets
`define SRE_ADDR_MST 8'h00
`define SRE_ADDR_CFG0 8'h04
`define SRE_ADDR_CFG2 8'h08
`define SRE_ADDR_SPC 8'h0C
`define SRE_ADDR_SST 8'h10
`define SRE_ADDR_STATUS 8'h14
`define SRE_ADDR_FETCH 8'h18

// ============================================================
// Field positions, bit 0 is the least significant bit
`define SRE_MST_EXC_ENDIAN 16
`define SRE_MST_LITTLE 0
`define SRE_MST_PREFIX 6
`define SRE_SST_RECOVER 1
`define SRE_CFG0_ICACHE 15
`define SRE_CFG2_TRUE_LITTLE 27

// ============================================================
// Masks and values
`define SRE_MST_CLR_MASK 32'h0006_EFB2
`define SRE_RESET_OFFSET 32'h0000_0100
`define SRE_PREFIX_BASE 32'hFFF0_0000
`define SRE_HR_MST_PREFIX 32'h0000_0040
`define SRE_HR_MST_TRUE 32'h0001_0001
`define SRE_HR_CFG2_TRUE 32'h0800_0000
`define SRE_ZERO32 32'h0000_0000
`define SRE_RESP_OKAY 2'h0
`define SRE_RESP_SLVERR 2'h2

`endif

// ### rtl/sre_pkg.sv
// Types and shared functions of the soft reset exception unit
package sre_pkg;

  typedef enum logic [2:0] {
    SRE_IDLE = 3'b001,
    SRE_DRAIN = 3'b010,
    SRE_VECTOR = 3'b100
  } sre_state_t;

  typedef enum logic [1:0] {
    SRE_END_BIG = 2'h0,
    SRE_END_MOD = 2'h1,
    SRE_END_TRUE = 2'h2
  } sre_endian_t;

  // Handler endian from exception endian and true little enable
  function automatic sre_endian_t endian_of(input logic exc_end,
                                            input logic true_en);
    if (!exc_end) begin
      endian_of = SRE_END_BIG;
    end else if (true_en) begin
      endian_of = SRE_END_TRUE;
    end else begin
      endian_of = SRE_END_MOD;
    end
  endfunction

  // Reset handler address from the prefix bit
  function automatic logic [31:0] vector_of(input logic prefix);
    vector_of = (prefix ? 32'hFFF0_0000 : 32'h0000_0000) | 32'h0000_0100;
  endfunction

  // Byte lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

endpackage

// ### rtl/sre_exc_if.sv
// Signals shared by the top, the exception calculator and hard reset logic
`timescale 1ns/1ns
interface sre_exc_if;
  logic [31:0] mst;
  logic [31:0] cfg0;
  logic [31:0] cfg2;
  logic corrupt;
  logic [31:0] exc_mst;
  logic [31:0] exc_sst;
  logic [31:0] exc_cfg0;
  logic [31:0] exc_vector;
  sre_pkg::sre_endian_t exc_endian;
  logic hr_apply;
  logic [31:0] hr_mst;
  logic [31:0] hr_cfg2;
  logic hr_true;

  modport top (output mst, cfg0, cfg2, corrupt,
               input exc_mst, exc_sst, exc_cfg0, exc_vector, exc_endian,
               input hr_apply, hr_mst, hr_cfg2, hr_true);
  modport calc (input mst, cfg0, cfg2, corrupt,
                output exc_mst, exc_sst, exc_cfg0, exc_vector, exc_endian);
  modport hrst (output hr_apply, hr_mst, hr_cfg2, hr_true);
endinterface

// ### rtl/sre_exc_calc.sv
// Register values the soft reset exception writes when taken
`timescale 1ns/1ns
`include "sre_cfg.svh"
module sre_exc_calc (
  sre_exc_if.calc x
);

  // ============================================================
  // Exception results
  always_comb begin
    x.exc_mst = x.mst & ~`SRE_MST_CLR_MASK;
    x.exc_mst[`SRE_MST_LITTLE] = x.mst[`SRE_MST_EXC_ENDIAN];
    x.exc_sst = {16'h0000, x.mst[15:0]};
    if (x.corrupt) begin
      x.exc_sst[`SRE_SST_RECOVER] = 1'b0;
    end
    x.exc_cfg0 = x.cfg0;
    x.exc_cfg0[`SRE_CFG0_ICACHE] = 1'b0;
    x.exc_vector = sre_pkg::vector_of(x.mst[`SRE_MST_PREFIX]);
    x.exc_endian = sre_pkg::endian_of(x.mst[`SRE_MST_EXC_ENDIAN],
        x.cfg2[`SRE_CFG2_TRUE_LITTLE]);
  end

endmodule

// ### rtl/sre_hreset.sv
// Hard reset release: strap capture and initial state values
`timescale 1ns/1ns
`include "sre_cfg.svh"
module sre_hreset (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hreset_in,
  input wire logic tle_strap,
  input wire logic prefix_strap,
  sre_exc_if.hrst x
);

  logic pending_reg;
  logic release_now;

  // Bus reset counts as a hard reset released at the first clean edge
  assign release_now = pending_reg && !hreset_in;

  // ============================================================
  // Pending hard reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= 1'b1;
    end else begin
      pending_reg <= hreset_in;
    end
  end

  // ============================================================
  // Initial values caught at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x.hr_apply <= 1'b0;
      x.hr_mst <= `SRE_ZERO32;
      x.hr_cfg2 <= `SRE_ZERO32;
      x.hr_true <= 1'b0;
    end else begin
      x.hr_apply <= release_now;
      if (release_now) begin
        x.hr_true <= tle_strap;
        x.hr_cfg2 <= tle_strap ? `SRE_HR_CFG2_TRUE : `SRE_ZERO32;
        x.hr_mst <= (tle_strap ? `SRE_HR_MST_TRUE : `SRE_ZERO32)
            | (prefix_strap ? `SRE_HR_MST_PREFIX : `SRE_ZERO32);
      end
    end
  end

endmodule

// ### rtl/sre_top.sv
// Soft reset exception unit with AXI4-Lite register access
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "sre_cfg.svh"
module sre_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sreset_in,
  input wire logic hreset_in,
  input wire logic tle_strap,
  input wire logic prefix_strap,
  input wire logic mcheck_in,
  input wire logic [31:0] next_pc_in,
  input wire logic instr_done_in,
  input wire logic sq_empty_in,
  input wire logic state_corrupt_in,
  output logic block_completion,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  output sre_pkg::sre_endian_t handler_endian,
  output logic icache_enable
);

  sre_exc_if x ();

  sre_pkg::sre_state_t state_reg;
  sre_pkg::sre_state_t state_next;
  logic [31:0] mst_reg;
  logic [31:0] cfg0_reg;
  logic [31:0] cfg2_reg;
  logic [31:0] spc_reg;
  logic [31:0] sst_reg;
  logic sreset_prev_reg;
  logic done_seen_reg;
  logic unrec_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic sreset_rise;
  logic drain_done;
  logic take;
  logic wr_do;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] status_word;

  assign x.mst = mst_reg;
  assign x.cfg0 = cfg0_reg;
  assign x.cfg2 = cfg2_reg;
  assign x.corrupt = unrec_reg | state_corrupt_in;

  sre_exc_calc u_calc (
    .x(x.calc)
  );

  sre_hreset u_hreset (
    .aclk(aclk),
    .aresetn(aresetn),
    .hreset_in(hreset_in),
    .tle_strap(tle_strap),
    .prefix_strap(prefix_strap),
    .x(x.hrst)
  );

  // ============================================================
  // Sequencing of the soft reset
  // Rising edge detect without any enable bit; only a hard reset or a soft reset already in progress masks it
  assign sreset_rise = sreset_in && !sreset_prev_reg;
  assign drain_done = (done_seen_reg || instr_done_in) && sq_empty_in;
  // A machine check in the same cycle goes first
  assign take = (state_reg == sre_pkg::SRE_VECTOR);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sre_pkg::SRE_IDLE: begin
        if (sreset_rise) begin
          state_next = sre_pkg::SRE_DRAIN;
        end
      end
      sre_pkg::SRE_DRAIN: begin
        if (drain_done && !mcheck_in) begin
          state_next = sre_pkg::SRE_VECTOR;
        end
      end
      sre_pkg::SRE_VECTOR: begin
        state_next = sre_pkg::SRE_IDLE;
      end
      default: begin
        state_next = sre_pkg::SRE_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= sre_pkg::SRE_IDLE;
      sreset_prev_reg <= 1'b0;
    end else if (hreset_in || x.hr_apply) begin
      state_reg <= sre_pkg::SRE_IDLE;
      sreset_prev_reg <= sreset_in;
    end else begin
      state_reg <= state_next;
      sreset_prev_reg <= sreset_in;
    end
  end

  // Next instruction completion and machine check tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_seen_reg <= 1'b0;
      unrec_reg <= 1'b0;
    end else if (state_reg != sre_pkg::SRE_DRAIN) begin
      done_seen_reg <= 1'b0;
      // A hard reset also drops a flag left by a cut drain
      unrec_reg <= (take || x.hr_apply) ? 1'b0 : unrec_reg;
    end else begin
      done_seen_reg <= done_seen_reg || instr_done_in;
      unrec_reg <= unrec_reg || mcheck_in;
    end
  end

  // ============================================================
  // Pipeline outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_completion <= 1'b0;
    end else if (hreset_in || x.hr_apply) begin
      block_completion <= 1'b0;
    end else begin
      block_completion <= (state_next == sre_pkg::SRE_DRAIN);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_req <= 1'b0;
      fetch_addr <= `SRE_ZERO32;
      handler_endian <= sre_pkg::SRE_END_BIG;
    end else if (x.hr_apply) begin
      fetch_req <= 1'b1;
      fetch_addr <= sre_pkg::vector_of(x.hr_mst[`SRE_MST_PREFIX]);
      handler_endian <= sre_pkg::endian_of(x.hr_true, x.hr_true);
    end else if (take) begin
      fetch_req <= 1'b1;
      fetch_addr <= x.exc_vector;
      handler_endian <= x.exc_endian;
    end else begin
      fetch_req <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icache_enable <= 1'b0;
    end else begin
      icache_enable <= take ? 1'b0 : cfg0_reg[`SRE_CFG0_ICACHE];
    end
  end

  // ============================================================
  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= `SRE_ZERO32;
      w_strb_reg <= 4'h0;
    end else if (wr_do) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_bvalid && !wr_do
          && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_reg && !s_axi_bvalid && !wr_do
          && !(s_axi_wvalid && s_axi_wready);
    end
  end

  assign wr_do = aw_got_reg && w_got_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRE_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      case (wr_addr)
        `SRE_ADDR_MST, `SRE_ADDR_CFG0, `SRE_ADDR_CFG2, `SRE_ADDR_SPC,
        `SRE_ADDR_SST, `SRE_ADDR_STATUS, `SRE_ADDR_FETCH: begin
          s_axi_bresp <= `SRE_RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= `SRE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ============================================================
  // Architected registers; hard reset beats the exception beats software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_reg <= `SRE_ZERO32;
    end else if (x.hr_apply) begin
      mst_reg <= x.hr_mst;
    end else if (take) begin
      mst_reg <= x.exc_mst;
    end else if (wr_do && wr_addr == `SRE_ADDR_MST) begin
      mst_reg <= sre_pkg::merge(mst_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg0_reg <= `SRE_ZERO32;
    end else if (x.hr_apply) begin
      cfg0_reg <= `SRE_ZERO32;
    end else if (take) begin
      cfg0_reg <= x.exc_cfg0;
    end else if (wr_do && wr_addr == `SRE_ADDR_CFG0) begin
      cfg0_reg <= sre_pkg::merge(cfg0_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg2_reg <= `SRE_ZERO32;
    end else if (x.hr_apply) begin
      cfg2_reg <= x.hr_cfg2;
    end else if (wr_do && wr_addr == `SRE_ADDR_CFG2) begin
      cfg2_reg <= sre_pkg::merge(cfg2_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spc_reg <= `SRE_ZERO32;
    end else if (x.hr_apply) begin
      spc_reg <= `SRE_ZERO32;
    end else if (take) begin
      spc_reg <= next_pc_in;
    end else if (wr_do && wr_addr == `SRE_ADDR_SPC) begin
      spc_reg <= sre_pkg::merge(spc_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sst_reg <= `SRE_ZERO32;
    end else if (x.hr_apply) begin
      sst_reg <= `SRE_ZERO32;
    end else if (take) begin
      sst_reg <= x.exc_sst;
    end else if (wr_do && wr_addr == `SRE_ADDR_SST) begin
      sst_reg <= sre_pkg::merge(sst_reg, wr_data, wr_strb);
    end
  end

  // ============================================================
  // Read channel
  assign status_word = {23'h0, x.hr_true, unrec_reg,
                        handler_endian, state_reg, 1'b0, block_completion};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `SRE_ZERO32;
      s_axi_rresp <= `SRE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SRE_RESP_OKAY;
      case (s_axi_araddr)
        `SRE_ADDR_MST: s_axi_rdata <= mst_reg;
        `SRE_ADDR_CFG0: s_axi_rdata <= cfg0_reg;
        `SRE_ADDR_CFG2: s_axi_rdata <= cfg2_reg;
        `SRE_ADDR_SPC: s_axi_rdata <= spc_reg;
        `SRE_ADDR_SST: s_axi_rdata <= sst_reg;
        `SRE_ADDR_STATUS: s_axi_rdata <= status_word;
        `SRE_ADDR_FETCH: s_axi_rdata <= fetch_addr;
        default: begin
          s_axi_rdata <= `SRE_ZERO32;
          s_axi_rresp <= `SRE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### tb/sre_top_asserts.sv
// Port checks for the soft reset exception unit
`timescale 1ns/1ns
module sre_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sreset_in,
  input wire logic hreset_in,
  input wire logic mcheck_in,
  input wire logic sq_empty_in,
  input wire logic block_completion,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire sre_pkg::sre_endian_t handler_endian,
  input wire logic icache_enable
);
  logic [2:0] quiet_cnt;
  logic [1:0] block_d;
  // Cycles since a bus or hard reset; the hard reset fetch falls inside this span
  // Block two samples back marks a fetch that ends a drain
  always_ff @(posedge aclk) begin
    block_d <= {block_d[0], block_completion};
    if (!aresetn || hreset_in) begin
      quiet_cnt <= 3'h0;
    end else if (quiet_cnt != 3'h7) begin
      quiet_cnt <= quiet_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ============================================================
  // Soft reset sequence, handler fetch and hard reset
  sr_take_a: assert property (
    $rose(sreset_in) && !block_completion && !hreset_in &&
    quiet_cnt > 3'h4 |=> block_completion)
    else $error("soft reset edge not taken");
  block_cause_a: assert property (
    $rose(block_completion) |-> $past(sreset_in) && !$past(sreset_in, 2))
    else $error("drain without a soft reset edge");
  drain_end_a: assert property (
    fetch_req && block_d[1] |->
    $past(sq_empty_in, 2) && !$past(mcheck_in, 2))
    else $error("fetch before drain complete");
  take_unblock_a: assert property (
    fetch_req && block_d[1] |-> !block_completion)
    else $error("completion still blocked at fetch");
  icache_off_a: assert property (
    fetch_req && block_d[1] |=> !icache_enable)
    else $error("icache still enabled after soft reset");
  vector_addr_a: assert property (
    fetch_req |-> fetch_addr == 32'hFFF0_0100 || fetch_addr == 32'h0000_0100)
    else $error("bad handler address");
  fetch_pulse_a: assert property (
    fetch_req |=> !fetch_req)
    else $error("fetch request longer than one cycle");
  fetch_hold_a: assert property (
    !fetch_req && quiet_cnt > 3'h2 |->
    $stable(fetch_addr) && $stable(handler_endian))
    else $error("handler address or endian moved");
  hreset_idle_a: assert property (
    hreset_in |=> !block_completion)
    else $error("drain kept during hard reset");
  cover property (fetch_req && block_d[1]);
  cover property (block_completion && mcheck_in);
  cover property (fetch_req && handler_endian == sre_pkg::SRE_END_TRUE);
endmodule

bind sre_top sre_top_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .sreset_in(sreset_in), .hreset_in(hreset_in), .mcheck_in(mcheck_in),
  .sq_empty_in(sq_empty_in), .block_completion(block_completion),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .handler_endian(handler_endian), .icache_enable(icache_enable));

// ### tb/sre_rst_model.sv
// System reset controller model: reset requests and straps
`timescale 1ns/1ns
module sre_rst_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic hreset_in,
  output logic sreset_in,
  output logic tle_strap,
  output logic prefix_strap
);
  logic tle_val = 1'b0;
  logic pfx_val = 1'b1;
  int hold_cnt = 3;
  initial begin
    hreset_in = 1'b0;
    sreset_in = 1'b0;
    tle_strap = 1'b0;
    prefix_strap = 1'b1;
  end
  // Straps hold only around reset release, then change every cycle
  always @(posedge aclk) begin
    if (!aresetn || hreset_in || hold_cnt > 0) begin
      tle_strap <= tle_val;
      prefix_strap <= pfx_val;
    end else begin
      tle_strap <= ~tle_strap;
      prefix_strap <= ~prefix_strap;
    end
    hold_cnt <= (!aresetn || hreset_in) ? 3 :
        (hold_cnt > 0 ? hold_cnt - 1 : 0);
  end
  task automatic hard_reset(input logic tle, input logic pfx);
    @(posedge aclk);
    tle_val <= tle;
    pfx_val <= pfx;
    hreset_in <= 1'b1;
    repeat (3) @(posedge aclk);
    hreset_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic soft_pulse;
    @(posedge aclk);
    sreset_in <= 1'b1;
    @(posedge aclk);
    sreset_in <= 1'b0;
  endtask
endmodule

// ### tb/soft_reset_exception_test.sv
// Self-checking bench for the soft reset exception unit
`timescale 1ns/1ns
module soft_reset_exception_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, next_pc_in = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, block_completion, fetch_req, icache_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, fetch_addr, m_mst, m_cfg0, m_cfg2;
  logic sreset_in, hreset_in, tle_strap, prefix_strap;
  logic mcheck_in = 1'b0, instr_done_in = 1'b0, sq_empty_in = 1'b0;
  logic state_corrupt_in = 1'b0, m_tle = 1'b0;
  sre_pkg::sre_endian_t handler_endian;
  int fail_count = 0, total_checks = 0, seed = 96158;
  always #5 aclk = ~aclk;
  sre_rst_model rst_u (.aclk, .aresetn, .hreset_in, .sreset_in, .tle_strap,
    .prefix_strap);
  sre_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sreset_in, .hreset_in, .tle_strap, .prefix_strap, .mcheck_in,
    .next_pc_in, .instr_done_in, .sq_empty_in, .state_corrupt_in,
    .block_completion, .fetch_req, .fetch_addr, .handler_endian,
    .icache_enable);
  // ============================================================
  // Comparison and bus tasks
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
      input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(what, ed, s_axi_rdata);
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // ============================================================
  // One soft reset against the integer model
  task automatic sr_run(input logic mc, input logic bad);
    logic [31:0] pc, sst, vec;
    logic [1:0] en;
    int n;
    pc = $random(seed);
    sst = {16'h0000, m_mst[15:0]};
    sst[1] = sst[1] & !mc & !bad;
    en = !m_mst[16] ? 2'h0 : (m_cfg2[27] ? 2'h2 : 2'h1);
    vec = m_mst[6] ? 32'hFFF0_0100 : 32'h0000_0100;
    repeat (2) @(posedge aclk);
    check("icache", {31'h0, m_cfg0[15]}, {31'h0, icache_enable});
    next_pc_in <= pc;
    state_corrupt_in <= bad;
    sq_empty_in <= 1'b0;
    rst_u.soft_pulse();
    repeat (3) @(posedge aclk);
    check("block", 32'h1, {31'h0, block_completion});
    instr_done_in <= 1'b1;
    sq_empty_in <= 1'b1;
    mcheck_in <= mc;
    @(posedge aclk);
    instr_done_in <= 1'b0;
    mcheck_in <= 1'b0;
    for (n = 0; n < 20 && fetch_req !== 1'b1; n++) @(posedge aclk);
    check("fetch req", 32'h1, {31'h0, fetch_req});
    check("unblock", 32'h0, {31'h0, block_completion});
    check("vector", vec, fetch_addr);
    check("endian", {30'h0, en}, {30'h0, handler_endian});
    m_mst = (m_mst & ~32'h0006_EFB3) | {31'h0, m_mst[16]};
    m_cfg0[15] = 1'b0;
    rdc("spc", 8'h0C, pc, 2'h0);
    rdc("sst", 8'h10, sst, 2'h0);
    rdc("mst", 8'h00, m_mst, 2'h0);
    rdc("cfg0", 8'h04, m_cfg0, 2'h0);
    rdc("fetch", 8'h18, vec, 2'h0);
    rdc("status", 8'h14, {23'h0, m_tle, 1'b0, en, 5'h04}, 2'h0);
    $display("soft reset test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    close_out();
  end
  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check("hr endian", 32'h0, {30'h0, handler_endian});
    check("hr vector", 32'hFFF0_0100, fetch_addr);
    rdc("mst", 8'h00, 32'h0000_0040, 2'h0);
    rdc("cfg2", 8'h08, 32'h0000_0000, 2'h0);
    rdc("hole", 8'h1C, 32'h0000_0000, 2'h2);
    wr(8'h1C, 32'hFFFF_FFFF, 2'h2);
    $display("power-up test done");
    m_mst = {16'h0001, 16'h0043};
    m_cfg2 = {16'h0800, 16'h0000};
    m_cfg0 = 32'h0000_8000;
    wr(8'h00, m_mst, 2'h0);
    wr(8'h08, m_cfg2, 2'h0);
    wr(8'h04, m_cfg0, 2'h0);
    sr_run(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      m_mst = $random(seed) | 32'h0000_0002;
      m_cfg2 = $random(seed);
      m_cfg0 = $random(seed);
      wr(8'h00, m_mst, 2'h0);
      wr(8'h08, m_cfg2, 2'h0);
      wr(8'h04, m_cfg0, 2'h0);
      sr_run(i == 2, i == 4);
    end
    sq_empty_in <= 1'b0;
    rst_u.soft_pulse();
    repeat (2) @(posedge aclk);
    m_tle = 1'b1;
    rst_u.hard_reset(1'b1, 1'b0);
    check("hr block", 32'h0, {31'h0, block_completion});
    check("hr endian", 32'h2, {30'h0, handler_endian});
    check("hr vector", 32'h0000_0100, fetch_addr);
    rdc("mst", 8'h00, 32'h0001_0001, 2'h0);
    rdc("cfg2", 8'h08, 32'h0800_0000, 2'h0);
    $display("hard reset test done");
    m_mst = 32'h0000_0000;
    m_cfg2 = 32'h0800_0000;
    m_cfg0 = 32'h0000_0000;
    wr(8'h00, m_mst, 2'h0);
    wr(8'h04, m_cfg0, 2'h0);
    sr_run(1'b0, 1'b0);
    close_out();
  end
endmodule
